/* pccr_pkg.sv */
// constants, register map and field layout of the loop clock control block
package pccr_pkg;

  // ==========================================================================
  // bus
  localparam int          ADDR_W    = 8;
  localparam int          DATA_W    = 32;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLV  = 2'h2;
  localparam logic [23:0] PAD_ZERO  = 24'h000000;

  // ==========================================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_LOOP_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_BW_CTRL   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FB_HIGH   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FB_LOW    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_VCO_RANGE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_REF_DIV   = 8'h14;

  // decoded register index
  localparam logic [2:0] IDX_LOOP_CTRL = 3'h0;
  localparam logic [2:0] IDX_BW_CTRL   = 3'h1;
  localparam logic [2:0] IDX_FB_HIGH   = 3'h2;
  localparam logic [2:0] IDX_FB_LOW    = 3'h3;
  localparam logic [2:0] IDX_VCO_RANGE = 3'h4;
  localparam logic [2:0] IDX_REF_DIV   = 3'h5;
  localparam logic [2:0] IDX_NONE      = 3'h7;

  // ==========================================================================
  // loop_control fields
  localparam int LC_IRQ_EN = 7;
  localparam int LC_FLAG   = 6;
  localparam int LC_EN     = 5;
  localparam int LC_SEL    = 4;
  localparam int LC_PRE_HI = 3;
  localparam int LC_PRE_LO = 2;
  localparam int LC_VPR_HI = 1;
  localparam int LC_VPR_LO = 0;

  // loop_bandwidth_control fields
  localparam int BW_AUTO  = 7;
  localparam int BW_LOCK  = 6;
  localparam int BW_TRACK = 5;

  // feedback_factor_high holds the top nibble
  localparam int FB_W     = 12;
  localparam int FB_HI_HI = 3;
  localparam int FB_HI_LO = 0;
  localparam int VR_W     = 8;
  localparam int RD_W     = 4;

  // ==========================================================================
  // reset values and the fixed one and zero settings
  localparam logic            EN_RST  = 1'b1;
  localparam logic [FB_W-1:0] FB_RST  = 12'h040;
  localparam logic [VR_W-1:0] VR_RST  = 8'h40;
  localparam logic [RD_W-1:0] RD_RST  = 4'h1;
  localparam logic [FB_W-1:0] FB_ONE  = 12'h001;
  localparam logic [RD_W-1:0] RD_ONE  = 4'h1;
  localparam logic [VR_W-1:0] VR_ZERO = 8'h00;

  // ==========================================================================
  // source switch-over: rising edges of each source waited for
  localparam logic [1:0] SWITCH_EDGES = 2'h3;
  localparam logic [1:0] CNT_ZERO     = 2'h0;
  localparam logic [1:0] CNT_ONE      = 2'h1;

  typedef enum logic [1:0] {
    CLK_RUN    = 2'b01,
    CLK_SWITCH = 2'b10
  } pccr_clk_state_t;

endpackage

/* pccr_top.sv */
// loop clock control and status registers behind an AXI4-Lite slave
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pccr_top (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst_b,
  // axi4-lite write address and data
  input  wire logic [pccr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [pccr_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  // axi4-lite write response
  output logic      [1:0]                  s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // axi4-lite read
  input  wire logic [pccr_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic      [pccr_pkg::DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]                  s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // analog side inputs, asynchronous
  input  wire logic                        oscClock,
  input  wire logic                        vcoClock,
  input  wire logic                        lockDetect,
  input  wire logic                        trackDetect,
  // loop settings and clock out
  output logic                             baseClockOut,
  output logic                             baseSourceActive,
  output logic                             lockChangeIrq,
  output logic                             loopEnable,
  output logic                             autoBandwidth,
  output logic                             trackingForce,
  output logic      [1:0]                  prescaler,
  output logic      [1:0]                  vcoPowerRange,
  output logic      [pccr_pkg::FB_W-1:0]   feedbackFactor,
  output logic      [pccr_pkg::VR_W-1:0]   vcoRangeFactor,
  output logic      [pccr_pkg::RD_W-1:0]   referenceDivisor
);

  typedef struct packed {
    logic                            oscS1;
    logic                            oscS2;
    logic                            oscPrev;
    logic                            vcoS1;
    logic                            vcoS2;
    logic                            vcoPrev;
    logic                            lockS1;
    logic                            lockS2;
    logic                            lockPrev;
    logic                            trkS1;
    logic                            trkS2;
    logic                            irqEn;
    logic                            flag;
    logic                            loopEnable;
    logic                            baseSel;
    logic [1:0]                      prescaler;
    logic [1:0]                      vcoPower;
    logic                            autoBw;
    logic                            manualTrack;
    logic [pccr_pkg::FB_W-1:0]       fbFactor;
    logic [pccr_pkg::VR_W-1:0]       vcoRange;
    logic [pccr_pkg::RD_W-1:0]       refDiv;
    logic [pccr_pkg::FB_W-1:0]       fbEff;
    logic [pccr_pkg::RD_W-1:0]       refEff;
    logic                            irq;
    pccr_pkg::pccr_clk_state_t       clkState;
    logic                            activeSel;
    logic                            baseOut;
    logic [1:0]                      oscCnt;
    logic [1:0]                      vcoCnt;
    logic                            awReady;
    logic                            awHave;
    logic [pccr_pkg::ADDR_W-1:0]     awAddr;
    logic                            wReady;
    logic                            wHave;
    logic [7:0]                      wData;
    logic                            wStrb0;
    logic                            bValid;
    logic [1:0]                      bResp;
    logic                            arReady;
    logic                            rValid;
    logic [pccr_pkg::DATA_W-1:0]     rData;
    logic [1:0]                      rResp;
  } pccr_regs_t;

  pccr_regs_t st;
  pccr_regs_t next_st;

  // ==========================================================================
  // helpers
  function automatic logic [2:0] decodeIdx(input logic [pccr_pkg::ADDR_W-1:0] a);
    logic [2:0] idx;
    idx = pccr_pkg::IDX_NONE;
    if (a == pccr_pkg::OFS_LOOP_CTRL) begin
      idx = pccr_pkg::IDX_LOOP_CTRL;
    end else if (a == pccr_pkg::OFS_BW_CTRL) begin
      idx = pccr_pkg::IDX_BW_CTRL;
    end else if (a == pccr_pkg::OFS_FB_HIGH) begin
      idx = pccr_pkg::IDX_FB_HIGH;
    end else if (a == pccr_pkg::OFS_FB_LOW) begin
      idx = pccr_pkg::IDX_FB_LOW;
    end else if (a == pccr_pkg::OFS_VCO_RANGE) begin
      idx = pccr_pkg::IDX_VCO_RANGE;
    end else if (a == pccr_pkg::OFS_REF_DIV) begin
      idx = pccr_pkg::IDX_REF_DIV;
    end
    return idx;
  endfunction

  // a zero divider setting behaves as one
  function automatic logic [pccr_pkg::FB_W-1:0] zeroAsOne(input logic [pccr_pkg::FB_W-1:0] v);
    return (v == '0) ? pccr_pkg::FB_ONE : v;
  endfunction

  logic       lockToggle;
  logic       oscRise;
  logic       vcoRise;
  logic [2:0] rdIdx;
  logic [2:0] wrIdx;
  logic       rdTake;
  logic       trackView;

  assign lockToggle = st.lockS2 ^ st.lockPrev;
  assign oscRise    = st.oscS2 & ~st.oscPrev;
  assign vcoRise    = st.vcoS2 & ~st.vcoPrev;
  assign rdIdx      = decodeIdx(s_axi_araddr);
  assign wrIdx      = decodeIdx(st.awAddr);
  assign rdTake     = s_axi_arvalid & st.arReady;
  assign trackView  = st.autoBw ? st.trkS2 : st.manualTrack;

  // ==========================================================================
  // next state
  always_comb begin
    logic [7:0]                rb;
    logic [7:0]                d;
    logic [pccr_pkg::FB_W-1:0] rdExt;
    logic [pccr_pkg::FB_W-1:0] rdOne;
    rb      = 8'h00;
    d       = st.wData;
    rdExt   = '0;
    rdOne   = '0;
    next_st = st;

    // two-stage capture of asynchronous inputs
    next_st.oscS1    = oscClock;
    next_st.oscS2    = st.oscS1;
    next_st.oscPrev  = st.oscS2;
    next_st.vcoS1    = vcoClock;
    next_st.vcoS2    = st.vcoS1;
    next_st.vcoPrev  = st.vcoS2;
    next_st.lockS1   = lockDetect;
    next_st.lockS2   = st.lockS1;
    next_st.lockPrev = st.lockS2;
    next_st.trkS1    = trackDetect;
    next_st.trkS2    = st.trkS1;

    // ------------------------------------------------------------------------
    // write channel: address and data taken in either order
    if (s_axi_awvalid && st.awReady) begin
      next_st.awHave = 1'b1;
      next_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wReady) begin
      next_st.wHave  = 1'b1;
      next_st.wData  = s_axi_wdata[7:0];
      next_st.wStrb0 = s_axi_wstrb[0];
    end
    if (st.bValid && s_axi_bready) begin
      next_st.bValid = 1'b0;
    end
    if (st.awHave && st.wHave && !st.bValid) begin
      next_st.awHave = 1'b0;
      next_st.wHave  = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp  = (wrIdx == pccr_pkg::IDX_NONE) ? pccr_pkg::RESP_SLV : pccr_pkg::RESP_OKAY;
      if (st.wStrb0) begin
        if (wrIdx == pccr_pkg::IDX_LOOP_CTRL) begin
          if (st.autoBw) begin
            next_st.irqEn = d[pccr_pkg::LC_IRQ_EN];
          end
          next_st.loopEnable = d[pccr_pkg::LC_EN] | st.baseSel;
          // no select in the same write that turns the loop off
          next_st.baseSel    = d[pccr_pkg::LC_SEL] & st.loopEnable & next_st.loopEnable;
          if (!st.loopEnable) begin
            next_st.prescaler = d[pccr_pkg::LC_PRE_HI:pccr_pkg::LC_PRE_LO];
            next_st.vcoPower  = d[pccr_pkg::LC_VPR_HI:pccr_pkg::LC_VPR_LO];
          end
        end else if (wrIdx == pccr_pkg::IDX_BW_CTRL) begin
          // lock position is ignored: its write-one function is test only
          next_st.autoBw = d[pccr_pkg::BW_AUTO];
          if (!st.autoBw) begin
            next_st.manualTrack = d[pccr_pkg::BW_TRACK];
          end
        end else if (wrIdx == pccr_pkg::IDX_FB_HIGH) begin
          if (!st.loopEnable) begin
            next_st.fbFactor[pccr_pkg::FB_W-1:8] = d[pccr_pkg::FB_HI_HI:pccr_pkg::FB_HI_LO];
          end
        end else if (wrIdx == pccr_pkg::IDX_FB_LOW) begin
          if (!st.loopEnable) begin
            next_st.fbFactor[7:0] = d;
          end
        end else if (wrIdx == pccr_pkg::IDX_VCO_RANGE) begin
          if (!st.loopEnable) begin
            next_st.vcoRange = d;
          end
        end else if (wrIdx == pccr_pkg::IDX_REF_DIV) begin
          if (!st.loopEnable) begin
            next_st.refDiv = d[pccr_pkg::RD_W-1:0];
          end
        end
      end
    end

    // ------------------------------------------------------------------------
    // read channel
    if (st.rValid && s_axi_rready) begin
      next_st.rValid = 1'b0;
    end
    if (rdTake) begin
      if (rdIdx == pccr_pkg::IDX_LOOP_CTRL) begin
        rb[pccr_pkg::LC_IRQ_EN] = st.irqEn & st.autoBw;
        rb[pccr_pkg::LC_FLAG]   = st.flag & st.autoBw;
        rb[pccr_pkg::LC_EN]     = st.loopEnable;
        rb[pccr_pkg::LC_SEL]    = st.baseSel;
        rb[pccr_pkg::LC_PRE_HI:pccr_pkg::LC_PRE_LO] = st.prescaler;
        rb[pccr_pkg::LC_VPR_HI:pccr_pkg::LC_VPR_LO] = st.vcoPower;
        next_st.flag = 1'b0;
      end else if (rdIdx == pccr_pkg::IDX_BW_CTRL) begin
        rb[pccr_pkg::BW_AUTO]  = st.autoBw;
        rb[pccr_pkg::BW_LOCK]  = st.lockS2 & st.autoBw;
        rb[pccr_pkg::BW_TRACK] = trackView;
      end else if (rdIdx == pccr_pkg::IDX_FB_HIGH) begin
        rb[pccr_pkg::FB_HI_HI:pccr_pkg::FB_HI_LO] = st.fbFactor[pccr_pkg::FB_W-1:8];
      end else if (rdIdx == pccr_pkg::IDX_FB_LOW) begin
        rb = st.fbFactor[7:0];
      end else if (rdIdx == pccr_pkg::IDX_VCO_RANGE) begin
        rb = st.vcoRange;
      end else if (rdIdx == pccr_pkg::IDX_REF_DIV) begin
        rb[pccr_pkg::RD_W-1:0] = st.refDiv;
      end
      next_st.rData  = {pccr_pkg::PAD_ZERO, rb};
      next_st.rResp  = (rdIdx == pccr_pkg::IDX_NONE) ? pccr_pkg::RESP_SLV : pccr_pkg::RESP_OKAY;
      next_st.rValid = 1'b1;
    end

    // ------------------------------------------------------------------------
    // lock change flag: a toggle in the clearing cycle still sets it
    if (lockToggle && st.autoBw) begin
      next_st.flag = 1'b1;
    end
    // leaving auto mode clears it in the same edge
    if (!next_st.autoBw) begin
      next_st.flag = 1'b0;
    end

    // zero range factor overrides any loop enable or select write in the same cycle
    if (next_st.vcoRange == pccr_pkg::VR_ZERO) begin
      next_st.loopEnable = 1'b0;
      next_st.baseSel    = 1'b0;
    end

    rdExt          = {{(pccr_pkg::FB_W-pccr_pkg::RD_W){1'b0}}, next_st.refDiv};
    next_st.fbEff  = zeroAsOne(next_st.fbFactor);
    rdOne          = zeroAsOne(rdExt);
    next_st.refEff = rdOne[pccr_pkg::RD_W-1:0];
    next_st.irq    = next_st.flag & next_st.irqEn & next_st.autoBw;

    // ------------------------------------------------------------------------
    // base clock selector; output halves the active source
    case (st.clkState)
      pccr_pkg::CLK_RUN: begin
        if (st.baseSel != st.activeSel) begin
          next_st.clkState = pccr_pkg::CLK_SWITCH;
          next_st.oscCnt   = pccr_pkg::CNT_ZERO;
          next_st.vcoCnt   = pccr_pkg::CNT_ZERO;
        end else if (st.activeSel ? vcoRise : oscRise) begin
          next_st.baseOut = ~st.baseOut;
        end
      end
      pccr_pkg::CLK_SWITCH: begin
        // a stopped source stalls the switch; output stays frozen meanwhile
        if (oscRise && st.oscCnt != pccr_pkg::SWITCH_EDGES) begin
          next_st.oscCnt = st.oscCnt + pccr_pkg::CNT_ONE;
        end
        if (vcoRise && st.vcoCnt != pccr_pkg::SWITCH_EDGES) begin
          next_st.vcoCnt = st.vcoCnt + pccr_pkg::CNT_ONE;
        end
        if (st.oscCnt == pccr_pkg::SWITCH_EDGES && st.vcoCnt == pccr_pkg::SWITCH_EDGES) begin
          next_st.activeSel = st.baseSel;
          next_st.clkState  = pccr_pkg::CLK_RUN;
        end
      end
      default: begin
        next_st.clkState = pccr_pkg::CLK_RUN;
      end
    endcase

    // ready flags follow the holding state so outputs stay registered
    next_st.awReady = ~next_st.awHave & ~next_st.bValid;
    next_st.wReady  = ~next_st.wHave & ~next_st.bValid;
    next_st.arReady = ~next_st.rValid;
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st            <= '0;
      st.loopEnable <= pccr_pkg::EN_RST;
      st.fbFactor   <= pccr_pkg::FB_RST;
      st.vcoRange   <= pccr_pkg::VR_RST;
      st.refDiv     <= pccr_pkg::RD_RST;
      st.fbEff      <= pccr_pkg::FB_RST;
      st.refEff     <= pccr_pkg::RD_RST;
      st.clkState   <= pccr_pkg::CLK_RUN;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // outputs
  assign s_axi_awready    = st.awReady;
  assign s_axi_wready     = st.wReady;
  assign s_axi_bresp      = st.bResp;
  assign s_axi_bvalid     = st.bValid;
  assign s_axi_arready    = st.arReady;
  assign s_axi_rdata      = st.rData;
  assign s_axi_rresp      = st.rResp;
  assign s_axi_rvalid     = st.rValid;
  assign baseClockOut     = st.baseOut;
  assign baseSourceActive = st.activeSel;
  assign lockChangeIrq    = st.irq;
  assign loopEnable       = st.loopEnable;
  assign autoBandwidth    = st.autoBw;
  assign trackingForce    = st.manualTrack;
  assign prescaler        = st.prescaler;
  assign vcoPowerRange    = st.vcoPower;
  assign feedbackFactor   = st.fbEff;
  assign vcoRangeFactor   = st.vcoRange;
  assign referenceDivisor = st.refEff;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_irq_from_flag: assert property ((st.flag && st.irqEn && st.autoBw) |-> lockChangeIrq)
    else $error("flag with enable did not raise interrupt");
  a_manual_no_irq: assert property (!st.autoBw |-> (!lockChangeIrq && !st.flag))
    else $error("interrupt or flag present in manual mode");
  a_read_clears_flag: assert property ((rdTake && rdIdx == pccr_pkg::IDX_LOOP_CTRL
      && !lockToggle) |=> !st.flag)
    else $error("loop control read did not clear flag");
  a_sel_needs_loop: assert property (st.baseSel |-> st.loopEnable)
    else $error("source select set while loop off");
  a_range_zero_off: assert property ((st.vcoRange == pccr_pkg::VR_ZERO)
      |-> (!st.loopEnable && !st.baseSel))
    else $error("zero range factor left loop running");
  a_prot_prescaler: assert property (st.loopEnable |=> (st.prescaler == $past(st.prescaler)
      && st.fbFactor == $past(st.fbFactor) && st.refDiv == $past(st.refDiv)))
    else $error("protected field changed while loop enabled");
  a_clk_stasis: assert property ((st.clkState == pccr_pkg::CLK_SWITCH) |=>
      $stable(baseClockOut))
    else $error("base clock moved during switch-over");
  a_track_shadow: assert property (st.autoBw |=> $stable(st.manualTrack))
    else $error("shadow tracking value changed in auto mode");
  a_ien_manual_hold: assert property (!st.autoBw |=> $stable(st.irqEn))
    else $error("irq enable written in manual mode");

endmodule

`default_nettype wire

/* tb_pccr_top.sv */
// self-checking testbench for the loop clock control registers
`timescale 1ns/1ps
`default_nettype none

module tb_pccr_top;
  // ==========================================================================
  // signals
  localparam logic [7:0] LC = pccr_pkg::OFS_LOOP_CTRL;
  localparam logic [7:0] BW = pccr_pkg::OFS_BW_CTRL;
  localparam logic [7:0] FH = pccr_pkg::OFS_FB_HIGH;
  localparam logic [7:0] FL = pccr_pkg::OFS_FB_LOW;
  localparam logic [7:0] VR = pccr_pkg::OFS_VCO_RANGE;
  localparam logic [7:0] RD = pccr_pkg::OFS_REF_DIV;
  localparam int         OSC_P = 8;
  localparam int         VCO_P = 6;
  logic        clk_sys = 1'b0;
  logic        rst_b   = 1'b0;
  logic [7:0]  awAddr  = 8'h00;
  logic [7:0]  arAddr  = 8'h00;
  logic [31:0] wData   = 32'h00000000;
  logic        awValid = 1'b0, wValid = 1'b0, arValid = 1'b0;
  logic        lockIn  = 1'b0, trackIn = 1'b0, oscIn = 1'b0, vcoIn = 1'b0;
  logic        awRdy, wRdy, bValid, arRdy, rValid, baseClk, srcAct, irq, loopEn, trackF;
  logic [1:0]  bResp, rResp, pre, vpr, resp;
  logic [31:0] rData, rVal;
  logic [11:0] fb;
  logic [3:0]  rdOut;
  logic [3:0]  wStrb  = 4'hF;
  logic        autoBw;
  logic [7:0]  vrOut;
  logic [3:0]  phase  = 4'h0;
  int          errors = 0;
  int          checks = 0;

  pccr_top DUT (
    .clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awRdy), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wRdy), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(1'h1),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arRdy),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(1'h1),
    .oscClock(oscIn), .vcoClock(vcoIn), .lockDetect(lockIn), .trackDetect(trackIn),
    .baseClockOut(baseClk), .baseSourceActive(srcAct), .lockChangeIrq(irq),
    .loopEnable(loopEn), .autoBandwidth(autoBw), .trackingForce(trackF), .prescaler(pre),
    .vcoPowerRange(vpr), .feedbackFactor(fb), .vcoRangeFactor(vrOut),
    .referenceDivisor(rdOut));

  // ==========================================================================
  // clock and slow source clocks, osc period 8 and vco period 6 cycles
  initial forever #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    phase <= (phase == 4'hB) ? 4'h0 : phase + 4'h1;
    if (phase[1:0] == 2'h3) oscIn <= ~oscIn;
    if (phase % 4'h3 == 4'h2) vcoIn <= ~vcoIn;
  end

  // ==========================================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // a bound that runs out ends the run
  task automatic over();
    chk("wait bound", 32'h0, 32'h1);
    give_verdict();
  endtask

  task automatic busWr(input logic [7:0] a, input logic [7:0] d);
    int n;
    awAddr <= a;
    wData <= {24'h000000, d};
    awValid <= 1'b1;
    wValid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys);
      if (awValid && awRdy) awValid <= 1'b0;
      if (wValid && wRdy) wValid <= 1'b0;
      if (bValid === 1'b1) break;
    end
    if (n == 40) over();
    resp = bResp;
  endtask

  task automatic busRd(input logic [7:0] a);
    int n;
    arAddr <= a;
    arValid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys);
      if (arValid && arRdy) arValid <= 1'b0;
      if (rValid === 1'b1) break;
    end
    if (n == 40) over();
    rVal = rData;
    resp = rResp;
  endtask

  task automatic rc(input string what, input logic [7:0] a, input logic [7:0] exp);
    busRd(a);
    chk(what, {24'h000000, exp}, rVal);
    chk("rresp", {30'h0, pccr_pkg::RESP_OKAY}, {30'h0, resp});
  endtask

  // which 0 waits for the interrupt, 1 for the vco source
  task automatic waitHi(input int which);
    int n;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_sys);
      if ((which == 0 ? irq : srcAct) === 1'b1) break;
    end
    if (n == 100) over();
  endtask

  // cycles between two toggles of the base clock
  task automatic per(input string what, input int exp);
    int n;
    logic last;
    last = baseClk;
    for (n = 0; n < 50 && baseClk === last; n++) @(posedge clk_sys);
    last = baseClk;
    for (n = 1; n < 50; n++) begin
      @(posedge clk_sys);
      if (baseClk !== last) break;
    end
    chk(what, exp, n);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    rc("ctrl rst", LC, 8'h20);
    rc("bw rst", BW, 8'h00);
    rc("fb hi rst", FH, 8'h00);
    rc("fb lo rst", FL, 8'h40);
    rc("range rst", VR, 8'h40);
    rc("div rst", RD, 8'h01);
    busRd(8'h18);
    chk("unmapped rresp", {30'h0, pccr_pkg::RESP_SLV}, {30'h0, resp});
    busWr(8'h18, 8'hFF);
    chk("unmapped bresp", {30'h0, pccr_pkg::RESP_SLV}, {30'h0, resp});
    wStrb <= 4'h0;
    busWr(LC, 8'h00);
    wStrb <= 4'hF;
    rc("no strobe", LC, 8'h20);
  endtask

  task automatic t_lock();
    busWr(LC, 8'h3E);
    rc("sel while on", LC, 8'h30);
    busWr(LC, 8'h00);
    rc("enable held", LC, 8'h20);
    busWr(LC, 8'h00);
    busWr(LC, 8'h10);
    rc("sel while off", LC, 8'h00);
    busWr(LC, 8'h0E);
    rc("fields off", LC, 8'h0E);
    chk("prescaler", 32'h3, {30'h0, pre});
    chk("power range", 32'h2, {30'h0, vpr});
    busWr(FH, 8'h00);
    busWr(FL, 8'h00);
    busWr(RD, 8'h00);
    chk("fb zero", 32'h1, {20'h0, fb});
    chk("div zero", 32'h1, {28'h0, rdOut});
    busWr(RD, 8'h01);
    busWr(LC, 8'h30);
    rc("on with sel", LC, 8'h20);
    busWr(FL, 8'h55);
    rc("fb locked", FL, 8'h00);
    busWr(VR, 8'h12);
    rc("range locked", VR, 8'h40);
  endtask

  task automatic t_range();
    busWr(LC, 8'h00);
    busWr(VR, 8'h00);
    busWr(LC, 8'h30);
    rc("zero range", LC, 8'h00);
    chk("loop out", 32'h0, {31'h0, loopEn});
    chk("range out", 32'h0, {24'h0, vrOut});
    busWr(VR, 8'h40);
    busWr(LC, 8'h20);
    rc("range back", LC, 8'h20);
  endtask

  task automatic t_flag();
    busWr(LC, 8'hA0);
    rc("ie manual", LC, 8'h20);
    busWr(BW, 8'h80);
    chk("auto out", 32'h1, {31'h0, autoBw});
    busWr(LC, 8'hA0);
    lockIn <= 1'b1;
    waitHi(0);
    rc("lock seen", BW, 8'hC0);
    rc("flag set", LC, 8'hE0);
    rc("flag clear", LC, 8'hA0);
    chk("irq clear", 32'h0, {31'h0, irq});
    lockIn <= 1'b0;
    waitHi(0);
    busWr(BW, 8'h00);
    rc("manual mask", LC, 8'h20);
    chk("irq manual", 32'h0, {31'h0, irq});
  endtask

  task automatic t_track();
    busWr(BW, 8'h20);
    rc("track manual", BW, 8'h20);
    chk("track out", 32'h1, {31'h0, trackF});
    busWr(BW, 8'hA0);
    rc("auto status", BW, 8'h80);
    trackIn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rc("auto track", BW, 8'hA0);
    busWr(BW, 8'h00);
    trackIn <= 1'b0;
    rc("shadow", BW, 8'h20);
  endtask

  task automatic t_clock();
    per("osc period", OSC_P);
    busWr(LC, 8'h30);
    waitHi(1);
    per("vco period", VCO_P);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_lock();
    t_range();
    t_flag();
    t_track();
    t_clock();
    give_verdict();
  end
endmodule

`default_nettype wire
